// file: shared/lmcfg_pkg.sv
// constants for the led matrix display configuration bank
// assumes an apb slave at 40 mhz; counts are in grayscale clocks
package lmcfg_pkg;
	// register byte offsets, each 48-bit register split in two words
	localparam logic [11:0] OFS_TIMING_LO = 12'h000; // timing config bits 31-0
	localparam logic [11:0] OFS_TIMING_HI = 12'h004; // timing config bits 47-32
	localparam logic [11:0] OFS_LEVEL_LO  = 12'h008; // drive level bits 31-0
	localparam logic [11:0] OFS_LEVEL_HI  = 12'h00C; // drive level bits 47-32
	localparam logic [11:0] OFS_MULT      = 12'h010; // clock multiplier setting
	localparam logic [11:0] OFS_STATUS    = 12'h014; // derived timing readback
	// field positions in the timing register
	localparam int SEG_LSB = 0;
	localparam int SMB_LSB = 10;
	localparam int SMG_LSB = 15;
	localparam int SMR_LSB = 20;
	localparam int BR_LSB  = 25;
	localparam int BG_LSB  = 29;
	localparam int BB_LSB  = 33;
	localparam int SW_LSB  = 37;
	localparam int DK_LSB  = 41;
	localparam int RSV_BIT = 47;
	// reset values
	localparam logic [47:0] TIMING_RST = 48'h00E0_0094_A400; // smooth 01001b x3, switch 0111b
	localparam logic [47:0] LEVEL_RST  = 48'h0000_0000_0006; // red predischarge 0110b
	localparam logic [3:0]  MULT_RST   = 4'h7;                // 8x
	localparam logic [47:0] TIMING_WMASK = 48'h7FFF_FFFF_FFFF; // bit 47 read-only
	// segment and switch constants in grayscale clocks
	localparam logic [9:0]  SEG_LONG_CODE = 10'h3FF;
	localparam logic [10:0] SEG_SHORT = 11'h080;
	localparam logic [10:0] SEG_LONG  = 11'h400;
	localparam logic [8:0]  SW_ZERO   = 9'h02D; // 45
	localparam logic [8:0]  SW_STEP   = 9'h01E; // 30
endpackage

// file: shared/lmcfg_if.sv
// raw settings carried from the bank to the timing decoder, decoded counts carried back
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface lmcfg_if;
	logic [47:0] timing; // display timing config
	logic [3:0]  mult;   // clock multiplier code
	logic [10:0] seg_len;   // segment length in clocks
	logic [8:0]  switch_len; // row switch in clocks
	logic [4:0]  mult_factor; // multiplier factor
	modport bank (output timing, output mult, input seg_len, input switch_len,
		input mult_factor);
	modport dec (input timing, input mult, output seg_len, output switch_len,
		output mult_factor);
endinterface
`default_nettype wire

// file: verilog/lmcfg_decode.sv
// decoder turning raw codes into grayscale clock counts
// assumes inputs come from registers on the same clock
`timescale 1ns/1ps
`default_nettype none
module lmcfg_decode (
	lmcfg_if.dec c
);
	logic [9:0] seg_code; // segment length code
	logic [3:0] sw_code;  // row switch code
	assign seg_code = c.timing[lmcfg_pkg::SEG_LSB +: 10];
	assign sw_code  = c.timing[lmcfg_pkg::SW_LSB +: 4];
	// segment length; only the long code gives 1024
	always_comb begin
		if (seg_code == lmcfg_pkg::SEG_LONG_CODE) begin
			c.seg_len = lmcfg_pkg::SEG_LONG;
		end else begin
			c.seg_len = lmcfg_pkg::SEG_SHORT;
		end
	end
	// row switch interval
	always_comb begin
		if (sw_code == 4'h0) begin
			c.switch_len = lmcfg_pkg::SW_ZERO;
		end else begin
			c.switch_len = 9'((sw_code + 5'h01) * lmcfg_pkg::SW_STEP);
		end
	end
	// multiplier factor is code plus one
	assign c.mult_factor = {1'b0, c.mult} + 5'h01;
endmodule // lmcfg_decode
`default_nettype wire

// file: verilog/lmcfg_bank.sv
// apb register bank for the led matrix display configuration
// assumes a standard apb master on pclk, async active-low reset
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module lmcfg_bank (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [9:0]  segment_clock_count,
	output logic      [4:0]  low_gray_smooth_blue,
	output logic      [4:0]  low_gray_smooth_green,
	output logic      [4:0]  low_gray_smooth_red,
	output logic      [3:0]  low_gray_boost_red,
	output logic      [3:0]  low_gray_boost_green,
	output logic      [3:0]  low_gray_boost_blue,
	output logic      [3:0]  row_switch_interval,
	output logic      [5:0]  dark_field_trim,
	output logic      [3:0]  red_predischarge_level,
	output logic      [3:0]  clock_multiplier_setting,
	output logic      [10:0] segment_gclks,
	output logic      [8:0]  row_switch_gclks,
	output logic      [4:0]  grayscale_clock_factor
);
	lmcfg_if c (); // bank to decoder
	logic [47:0] display_timing_config; // timing register
	logic [47:0] drive_level_config;    // drive level register
	logic [3:0]  mult_reg;              // multiplier register
	logic [47:0] next_timing;           // next timing value
	logic [47:0] next_level;            // next level value
	logic [3:0]  next_mult;             // next multiplier value
	logic [31:0] next_prdata;           // next read data
	logic        next_pslverr;          // next error flag
	logic        acc;                   // access phase
	logic        hit;                   // address mapped
	logic [47:0] wr_lo;                 // low word merged
	logic [47:0] wr_hi;                 // high word merged
	logic        setup;                 // setup phase of a transfer
	logic        wr_tlo;                // write to timing low word
	logic        wr_thi;                // write to timing high word
	logic        wr_llo;                // write to drive level low word
	logic        wr_mul;                // write to multiplier

	lmcfg_decode u_dec (
		.c (c)
	);
	assign c.timing = display_timing_config;
	assign c.mult   = mult_reg;

	assign acc    = psel & penable;
	assign pready = 1'b1; // zero wait states
	assign hit = (paddr == lmcfg_pkg::OFS_TIMING_LO) || (paddr == lmcfg_pkg::OFS_TIMING_HI)
		|| (paddr == lmcfg_pkg::OFS_LEVEL_LO) || (paddr == lmcfg_pkg::OFS_LEVEL_HI)
		|| (paddr == lmcfg_pkg::OFS_MULT) || (paddr == lmcfg_pkg::OFS_STATUS);

	// next register values on a write access
	always_comb begin
		next_timing = display_timing_config;
		next_level  = drive_level_config;
		next_mult   = mult_reg;
		wr_lo = {display_timing_config[47:32], pwdata};
		wr_hi = {pwdata[15:0], display_timing_config[31:0]};
		if (acc && pwrite) begin
			if (paddr == lmcfg_pkg::OFS_TIMING_LO) begin
				next_timing = wr_lo & lmcfg_pkg::TIMING_WMASK;
			end else if (paddr == lmcfg_pkg::OFS_TIMING_HI) begin
				next_timing = wr_hi & lmcfg_pkg::TIMING_WMASK;
			end else if (paddr == lmcfg_pkg::OFS_LEVEL_LO) begin
				next_level = {drive_level_config[47:32], pwdata};
			end else if (paddr == lmcfg_pkg::OFS_LEVEL_HI) begin
				next_level = {pwdata[15:0], drive_level_config[31:0]};
			end else if (paddr == lmcfg_pkg::OFS_MULT) begin
				next_mult = pwdata[3:0];
			end
		end
	end

	// read mux and error answer
	always_comb begin
		next_prdata  = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (psel && !penable) begin
			if (paddr == lmcfg_pkg::OFS_TIMING_LO) begin
				next_prdata = display_timing_config[31:0];
			end else if (paddr == lmcfg_pkg::OFS_TIMING_HI) begin
				next_prdata = {16'h0000, 1'b0, display_timing_config[46:32]};
			end else if (paddr == lmcfg_pkg::OFS_LEVEL_LO) begin
				next_prdata = drive_level_config[31:0];
			end else if (paddr == lmcfg_pkg::OFS_LEVEL_HI) begin
				next_prdata = {16'h0000, drive_level_config[47:32]};
			end else if (paddr == lmcfg_pkg::OFS_MULT) begin
				next_prdata = {28'h0000000, mult_reg};
			end else if (paddr == lmcfg_pkg::OFS_STATUS) begin
				next_prdata = {7'h00, c.mult_factor, c.switch_len, c.seg_len};
			end
			next_pslverr = !hit;
		end else if (acc) begin
			next_prdata  = prdata;
			next_pslverr = pslverr;
		end
	end

	// register the bank
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			display_timing_config <= lmcfg_pkg::TIMING_RST;
			drive_level_config    <= lmcfg_pkg::LEVEL_RST;
			mult_reg              <= lmcfg_pkg::MULT_RST;
			prdata                <= 32'h0000_0000;
			pslverr               <= 1'b0;
		end else begin
			display_timing_config <= next_timing;
			drive_level_config    <= next_level;
			mult_reg              <= next_mult;
			prdata                <= next_prdata;
			pslverr               <= next_pslverr;
		end
	end

	// field outputs
	assign segment_clock_count   = display_timing_config[lmcfg_pkg::SEG_LSB +: 10];
	assign low_gray_smooth_blue  = display_timing_config[lmcfg_pkg::SMB_LSB +: 5];
	assign low_gray_smooth_green = display_timing_config[lmcfg_pkg::SMG_LSB +: 5];
	assign low_gray_smooth_red   = display_timing_config[lmcfg_pkg::SMR_LSB +: 5];
	assign low_gray_boost_red    = display_timing_config[lmcfg_pkg::BR_LSB +: 4];
	assign low_gray_boost_green  = display_timing_config[lmcfg_pkg::BG_LSB +: 4];
	assign low_gray_boost_blue   = display_timing_config[lmcfg_pkg::BB_LSB +: 4];
	assign row_switch_interval   = display_timing_config[lmcfg_pkg::SW_LSB +: 4];
	assign dark_field_trim       = display_timing_config[lmcfg_pkg::DK_LSB +: 6];
	assign red_predischarge_level = drive_level_config[3:0];
	assign clock_multiplier_setting = mult_reg;
	assign segment_gclks    = c.seg_len;
	assign row_switch_gclks = c.switch_len;
	assign grayscale_clock_factor = c.mult_factor;

	// assertions
	property p_rsv_zero;
		@(posedge pclk) disable iff (!presetn) display_timing_config[47] == 1'b0;
	endproperty
	a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit set");
	property p_seg;
		@(posedge pclk) disable iff (!presetn)
		segment_gclks == ((segment_clock_count == 10'h3FF) ? 11'h400 : 11'h080);
	endproperty
	a_seg: assert property (p_seg) else $error("segment length wrong");
	property p_sw;
		@(posedge pclk) disable iff (!presetn) (row_switch_interval != 4'h0) |->
		row_switch_gclks == 9'((row_switch_interval + 5'h01) * lmcfg_pkg::SW_STEP);
	endproperty
	a_sw: assert property (p_sw) else $error("row switch wrong");
	property p_sw0;
		@(posedge pclk) disable iff (!presetn) (row_switch_interval == 4'h0) |->
		row_switch_gclks == lmcfg_pkg::SW_ZERO;
	endproperty
	a_sw0: assert property (p_sw0) else $error("row switch zero wrong");
	property p_mult;
		@(posedge pclk) disable iff (!presetn)
		grayscale_clock_factor == {1'b0, clock_multiplier_setting} + 5'h01;
	endproperty
	a_mult: assert property (p_mult) else $error("multiplier wrong");
	property p_wr_lo;
		@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && paddr == 12'h000) |=> low_gray_smooth_red == $past(pwdata[24:20])
		&& low_gray_boost_red == $past(pwdata[28:25]);
	endproperty
	a_wr_lo: assert property (p_wr_lo) else $error("timing write lost");
	property p_wr_hi;
		@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && paddr == 12'h004) |=> dark_field_trim == $past(pwdata[14:9])
		&& low_gray_boost_blue == $past(pwdata[4:1]);
	endproperty
	a_wr_hi: assert property (p_wr_hi) else $error("timing high write lost");
	property p_wr_pdc;
		@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && paddr == 12'h008) |=> red_predischarge_level == $past(pwdata[3:0]);
	endproperty
	a_wr_pdc: assert property (p_wr_pdc) else $error("predischarge write lost");
	property p_green;
		@(posedge pclk) disable iff (!presetn) !(acc && pwrite) |=> $stable(low_gray_boost_green)
		&& $stable(low_gray_smooth_blue) && $stable(low_gray_smooth_green);
	endproperty
	a_green: assert property (p_green) else $error("field changed without write");
	property p_rd_hi;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && paddr == 12'h004) |=> prdata[31:15] == 17'h00000;
	endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("reserved read nonzero");
	// strobes watched by the assertions below
	assign setup  = psel & ~penable;
	assign wr_tlo = acc & pwrite & (paddr == lmcfg_pkg::OFS_TIMING_LO);
	assign wr_thi = acc & pwrite & (paddr == lmcfg_pkg::OFS_TIMING_HI);
	assign wr_llo = acc & pwrite & (paddr == lmcfg_pkg::OFS_LEVEL_LO);
	assign wr_mul = acc & pwrite & (paddr == lmcfg_pkg::OFS_MULT);

	// segment code lands from the low word
	property p_wr_seg;
		@(posedge pclk) disable iff (!presetn)
		wr_tlo |=>
		segment_clock_count == $past(pwdata[9:0]);
	endproperty
	a_wr_seg: assert property (p_wr_seg) else $error("segment write lost");
	// blue and green smoothing land from the low word
	property p_wr_smooth;
		@(posedge pclk) disable iff (!presetn)
		wr_tlo |=> low_gray_smooth_blue == $past(pwdata[14:10])
		&& low_gray_smooth_green == $past(pwdata[19:15]);
	endproperty
	a_wr_smooth: assert property (p_wr_smooth) else $error("smoothing write lost");
	// green boost low bits come from the low word
	property p_wr_green;
		@(posedge pclk) disable iff (!presetn)
		wr_tlo |=>
		low_gray_boost_green[2:0] == $past(pwdata[31:29]);
	endproperty
	a_wr_green: assert property (p_wr_green) else $error("green boost low lost");
	// green boost top bit comes from the high word
	property p_wr_green_hi;
		@(posedge pclk) disable iff (!presetn)
		wr_thi |=>
		low_gray_boost_green[3] == $past(pwdata[0]);
	endproperty
	a_wr_green_hi: assert property (p_wr_green_hi) else $error("green boost high lost");
	// row switch code lands from the high word
	property p_wr_switch;
		@(posedge pclk) disable iff (!presetn)
		wr_thi |=>
		row_switch_interval == $past(pwdata[8:5]);
	endproperty
	a_wr_switch: assert property (p_wr_switch) else $error("switch write lost");
	// multiplier code lands
	property p_wr_mult;
		@(posedge pclk) disable iff (!presetn)
		wr_mul |=>
		clock_multiplier_setting == $past(pwdata[3:0]);
	endproperty
	a_wr_mult: assert property (p_wr_mult) else $error("multiplier write lost");
	// red boost and segment move only on a low word write
	property p_hold_red;
		@(posedge pclk) disable iff (!presetn)
		!wr_tlo |=>
		$stable(low_gray_boost_red) && $stable(segment_clock_count);
	endproperty
	a_hold_red: assert property (p_hold_red) else $error("red boost changed");
	// trim and switch move only on a high word write
	property p_hold_trim;
		@(posedge pclk) disable iff (!presetn)
		!wr_thi |=>
		$stable(dark_field_trim) && $stable(row_switch_interval);
	endproperty
	a_hold_trim: assert property (p_hold_trim) else $error("trim changed");
	// predischarge code moves only on its own write
	property p_hold_pdc;
		@(posedge pclk) disable iff (!presetn)
		!wr_llo |=>
		$stable(red_predischarge_level);
	endproperty
	a_hold_pdc: assert property (p_hold_pdc) else $error("predischarge changed");
	// multiplier code moves only on its own write
	property p_hold_mult;
		@(posedge pclk) disable iff (!presetn)
		!wr_mul |=>
		$stable(clock_multiplier_setting);
	endproperty
	a_hold_mult: assert property (p_hold_mult) else $error("multiplier changed");
	// low word reads back every low field in place
	property p_rd_lo;
		@(posedge pclk) disable iff (!presetn)
		(setup && paddr == lmcfg_pkg::OFS_TIMING_LO) |=> prdata == {low_gray_boost_green[2:0],
		low_gray_boost_red, low_gray_smooth_red, low_gray_smooth_green, low_gray_smooth_blue, segment_clock_count};
	endproperty
	a_rd_lo: assert property (p_rd_lo) else $error("low word read wrong");
	// predischarge code reads back
	property p_rd_pdc;
		@(posedge pclk) disable iff (!presetn)
		(setup && paddr == lmcfg_pkg::OFS_LEVEL_LO) |=>
		prdata[3:0] == red_predischarge_level;
	endproperty
	a_rd_pdc: assert property (p_rd_pdc) else $error("predischarge read wrong");
	// multiplier reads back zero extended
	property p_rd_mult;
		@(posedge pclk) disable iff (!presetn)
		(setup && paddr == lmcfg_pkg::OFS_MULT) |=>
		prdata == {28'h0000000, clock_multiplier_setting};
	endproperty
	a_rd_mult: assert property (p_rd_mult) else $error("multiplier read wrong");
	// status word carries the decoded counts
	property p_rd_status;
		@(posedge pclk) disable iff (!presetn)
		(setup && paddr == lmcfg_pkg::OFS_STATUS) |=> prdata[19:11] == row_switch_gclks
		&& prdata[10:0] == segment_gclks && prdata[24:20] == grayscale_clock_factor;
	endproperty
	a_rd_status: assert property (p_rd_status) else $error("status read wrong");
	// unmapped address answers with an error and no data
	property p_err;
		@(posedge pclk) disable iff (!presetn)
		(setup && !hit) |=>
		pslverr && prdata == 32'h0000_0000;
	endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	c_wr: cover property (@(posedge pclk) disable iff (!presetn) acc && pwrite && hit);
	c_sw0: cover property (@(posedge pclk) disable iff (!presetn) row_switch_gclks == lmcfg_pkg::SW_ZERO);
	c_rd: cover property (@(posedge pclk) disable iff (!presetn) acc && !pwrite && hit);
	c_err: cover property (@(posedge pclk) disable iff (!presetn) acc && pslverr);
	c_long: cover property (@(posedge pclk) disable iff (!presetn) segment_gclks == 11'h400);
endmodule // lmcfg_bank
`default_nettype wire

// file: test/lmcfg_bank_tb.sv
// self-checking bench for the display configuration bank
// assumes lmcfg_bank as apb slave on a 40 mhz pclk
`timescale 1ns/1ps
`default_nettype none
module lmcfg_bank_tb;
	logic        pclk;       // bus clock
	logic        presetn;    // reset, active low
	logic        psel;       // apb select
	logic        penable;    // apb access phase
	logic        pwrite;     // apb direction
	logic [11:0] paddr;      // apb byte address
	logic [31:0] pwdata;     // apb write data
	logic [31:0] prdata;     // apb read data
	logic        pready;     // apb ready
	logic        pslverr;    // apb error
	logic [9:0]  seg;        // segment code
	logic [4:0]  smb, smg, smr; // smoothing codes
	logic [3:0]  bsr, bsg, bsb; // boost codes
	logic [3:0]  sw;         // row switch code
	logic [5:0]  dk;         // dark field trim
	logic [3:0]  pdc;        // red predischarge
	logic [3:0]  mul;        // multiplier code
	logic [10:0] seg_g;      // decoded segment
	logic [8:0]  sw_g;       // decoded switch
	logic [4:0]  fac;        // decoded factor
	int          num_errors; // mismatches
	int          checks;     // comparisons
	lmcfg_bank DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .segment_clock_count(seg), .low_gray_smooth_blue(smb),
		.low_gray_smooth_green(smg), .low_gray_smooth_red(smr), .low_gray_boost_red(bsr),
		.low_gray_boost_green(bsg), .low_gray_boost_blue(bsb), .row_switch_interval(sw),
		.dark_field_trim(dk), .red_predischarge_level(pdc), .clock_multiplier_setting(mul),
		.segment_gclks(seg_g), .row_switch_gclks(sw_g), .grayscale_clock_factor(fac));
	// 25 ns clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// verdict and end of run
	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// one compare for every value kind
	task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// one apb transfer, request held until pready seen at a rising edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// request held until pready is seen high at a rising edge
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata; // taken at the completing edge
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) chk(48'h0, 48'h1, "no pready");
	endtask
	// write, error must stay low
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		xfer(1'b1, a, d, r, e);
		chk(48'(e), 48'h0, "write error");
	endtask
	// read and compare
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		xfer(1'b0, a, 32'h0, r, e);
		chk(48'(r), 48'(exp), "readback");
		chk(48'(e), 48'h0, "read error");
	endtask
	// all timing field ports against a 48-bit image
	task automatic fields(input logic [47:0] v);
		@(negedge pclk);
		chk(48'(seg), 48'(v[9:0]), "seg");
		chk(48'({smb, smg, smr}), 48'({v[14:10], v[19:15], v[24:20]}), "smooth");
		chk(48'(bsr), 48'(v[28:25]), "boost red");
		chk(48'({bsg, bsb}), 48'({v[32:29], v[36:33]}), "boost gb");
		chk(48'(sw), 48'(v[40:37]), "switch");
		chk(48'(dk), 48'(v[46:41]), "dark");
	endtask
	// reset values at ports and through the bus
	task automatic t_reset();
		logic [47:0] v;
		v = {1'b0, 6'h00, 4'h7, 4'h0, 4'h0, 4'h0, 5'h09, 5'h09, 5'h09, 10'h000};
		fields(v);
		chk(48'({pdc, mul, fac}), 48'({4'h6, 4'h7, 5'h08}), "reset levels");
		rdc(lmcfg_pkg::OFS_TIMING_LO, v[31:0]);
		rdc(lmcfg_pkg::OFS_TIMING_HI, {16'h0000, v[47:32]});
		rdc(lmcfg_pkg::OFS_LEVEL_LO, 32'h0000_0006);
		$display("test reset done");
	endtask
	// field positions and the read-only top bit
	task automatic t_fields();
		logic [47:0] pat [2];
		pat = '{48'hFFFF_FFFF_FFFF, 48'h2B6D_9C35_A4E1};
		foreach (pat[i]) begin
			wr(lmcfg_pkg::OFS_TIMING_LO, pat[i][31:0]);
			wr(lmcfg_pkg::OFS_TIMING_HI, {16'hFFFF, pat[i][47:32]});
			fields(pat[i]);
			rdc(lmcfg_pkg::OFS_TIMING_HI, {17'h0, pat[i][46:32]});
		end
		$display("test fields done");
	endtask
	// segment lengths and switch intervals
	task automatic t_decode();
		logic [9:0]  c [6];
		logic [10:0] e [6];
		c = '{10'h07F, 10'h3FF, 10'h000, 10'h07E, 10'h080, 10'h3FE};
		e = '{11'h080, 11'h400, 11'h080, 11'h080, 11'h080, 11'h080};
		foreach (c[i]) begin
			wr(lmcfg_pkg::OFS_TIMING_LO, {22'h0, c[i]});
			@(negedge pclk);
			chk(48'(seg_g), 48'(e[i]), "segment clocks");
		end
		for (int n = 0; n < 16; n++) begin
			wr(lmcfg_pkg::OFS_TIMING_HI, 32'(n) << 5);
			@(negedge pclk);
			chk(48'(sw_g), (n == 0) ? 48'h2D : 48'((n + 1) * 32'h1E), "switch clocks");
		end
		$display("test decode done");
	endtask
	// multiplier codes, predischarge and an unmapped access
	task automatic t_level();
		logic [31:0] r;
		logic        e;
		for (int n = 0; n < 16; n++) begin
			wr(lmcfg_pkg::OFS_MULT, 32'(n));
			@(negedge pclk);
			chk(48'({mul, fac}), 48'({4'(n), 5'(n + 1)}), "multiplier");
		end
		rdc(lmcfg_pkg::OFS_MULT, 32'h0000_000F);
		rdc(lmcfg_pkg::OFS_STATUS, {7'h00, 5'h10, 9'h1E0, 11'h080});
		wr(lmcfg_pkg::OFS_STATUS, 32'hFFFF_FFFF);
		rdc(lmcfg_pkg::OFS_STATUS, {7'h00, 5'h10, 9'h1E0, 11'h080});
		wr(lmcfg_pkg::OFS_LEVEL_LO, 32'h0000_0009);
		wr(lmcfg_pkg::OFS_LEVEL_HI, 32'h0000_A5C3);
		rdc(lmcfg_pkg::OFS_LEVEL_HI, 32'h0000_A5C3);
		xfer(1'b1, 12'h040, 32'h0000_0003, r, e);
		chk(48'({e, r}), 48'({1'b1, 32'h0}), "unmapped");
		@(negedge pclk);
		chk(48'(pdc), 48'h9, "predischarge");
		rdc(lmcfg_pkg::OFS_LEVEL_LO, 32'h0000_0009);
		$display("test level done");
	endtask
	// a reset in mid-run brings every field back
	task automatic t_rerst();
		wr(lmcfg_pkg::OFS_TIMING_HI, 32'h0000_7FFF);
		wr(lmcfg_pkg::OFS_MULT, 32'h0000_0002);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		fields(48'h00E0_0094_A400);
		chk(48'({pdc, mul, fac}), 48'({4'h6, 4'h7, 5'h08}), "rerun levels");
		rdc(lmcfg_pkg::OFS_LEVEL_LO, 32'h0000_0006);
		$display("test rerst done");
	endtask
	// reset, then the tests in turn
	initial begin
		num_errors = 0; checks = 0;
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_fields();
		t_decode();
		t_level();
		t_rerst();
		stop_test();
	end
	// hang guard, well beyond the 59 transfers above
	initial begin
		#(25 * 20000);
		num_errors++;
		stop_test();
	end
endmodule // lmcfg_bank_tb
`default_nettype wire
